// ===== rx_read_pkg.sv
// Constants and shared types for the receive multi-PHY read port
package rx_read_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 4;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int PORT_W = 2;
  // Buffer entry: {has_data, sop, data}
  localparam int BUF_W = DATA_W + 2;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_SOP_BIT = DATA_W;
  localparam int BUF_HAS_BIT = DATA_W + 1;

  // ---------------------------------------------------------------
  // Addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] NULL_ADDR = 5'h1f;
  localparam logic [ADDR_W-1:0] SEL_RESET = NULL_ADDR;
  localparam logic [ADDR_W-1:0] PORT_COUNT_ADDR = 5'h04;
  localparam logic [1:0] BUF_COUNT_RESET = 2'h0;

  // Pin sampler: rfclk, renb_n, radr[4:0]
  localparam int PIN_W = ADDR_W + 2;
  localparam int PIN_CLK_BIT = ADDR_W + 1;
  localparam int PIN_ENB_BIT = ADDR_W;

  // Word fetch sequencer
  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_ASK,
    FETCH_TAKE
  } fetch_e;

endpackage

// ===== word_buffer.sv
// Two-entry valid/ready buffer in the receive data path
`timescale 1ns/1ps
module word_buffer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [rx_read_pkg::BUF_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [rx_read_pkg::BUF_W-1:0] out_data
);
  import rx_read_pkg::*;

  typedef struct packed {
    logic [BUF_DEPTH-1:0][BUF_W-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } buf_s;

  buf_s st_reg;
  buf_s st_next;
  logic push;
  logic pop;

  // ---------------------------------------------------------------
  // Flags come straight from the count, so full and empty are honest
  // ---------------------------------------------------------------
  assign in_ready = (st_reg.count != 2'(BUF_DEPTH));
  assign out_valid = (st_reg.count != 2'h0);
  assign out_data = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Next state; push and pop may share a cycle
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = ~st_reg.wr_ptr;
    end
    if (pop) begin
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 2'h1;
    end
    if (srst) begin
      st_next = '0;
      st_next.count = BUF_COUNT_RESET;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

endmodule

// ===== rx_multiphy_read_port.sv
// Receive multi-PHY read port: link-side pins over four receive FIFOs
`timescale 1ns/1ps
module rx_multiphy_read_port (
  input wire logic ref_clk,
  input wire logic srst,
  // Mode straps from core logic, same clock
  input wire logic cell_mode,
  input wire logic byte_level,
  input wire logic parity_odd,
  // Link pins; inputs asynchronous to ref_clk, outputs registered on it
  input wire logic rfclk,
  input wire logic renb_n,
  input wire logic [rx_read_pkg::ADDR_W-1:0] radr,
  output logic [rx_read_pkg::DATA_W-1:0] rdat_o,
  output logic rdat_oe,
  output logic rprty_o,
  output logic rprty_oe,
  output logic rsop_o,
  output logic rsop_oe,
  output logic rval,
  output logic rpa_o,
  output logic rpa_oe,
  output logic [rx_read_pkg::NUM_PORTS-1:0] direct_packet_avail,
  // Receive FIFO side, one stream per port
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] port_valid,
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] port_sop,
  input wire logic [rx_read_pkg::NUM_PORTS*rx_read_pkg::DATA_W-1:0]
    port_data,
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] pkt_avail,
  output logic [rx_read_pkg::NUM_PORTS-1:0] port_ready
);
  import rx_read_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] filt;
    logic clk_prev;
    logic [ADDR_W-1:0] sel;
    fetch_e fetch;
    logic [PORT_W-1:0] fetch_port;
    logic drive_pend;
    logic [DATA_W-1:0] dat;
    logic dat_oe;
    logic prty;
    logic prty_oe;
    logic sop;
    logic sop_oe;
    logic val;
    logic rpa;
    logic rpa_oe;
    logic [NUM_PORTS-1:0] dpa;
    logic [NUM_PORTS-1:0] rdy;
  } port_s;

  port_s st_reg;
  port_s st_next;

  logic buf_in_valid;
  logic buf_in_ready;
  logic [BUF_W-1:0] buf_in_data;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [BUF_W-1:0] buf_out_data;

  // Sampled link view from the filtered stage, plus mode, target and FIFO word helpers
  logic link_rise;
  logic enb_f;
  logic [ADDR_W-1:0] adr_f;
  logic pkt_level;
  logic [ADDR_W-1:0] target;
  logic [DATA_W-1:0] take_data;

  // Address decode: the null address is all ones and never below the
  // port count, so it can never alias onto a port
  function automatic logic owned(input logic [ADDR_W-1:0] a);
    owned = (a < PORT_COUNT_ADDR);
  endfunction

  // ---------------------------------------------------------------
  // Link view
  // ---------------------------------------------------------------
  // The interface clock is sampled like any pin; its rising edge is
  // taken from the filtered copy, and renb/radr travel through the same
  // stages so they stay aligned with it.
  assign link_rise = st_reg.filt[PIN_CLK_BIT] & ~st_reg.clk_prev;
  assign enb_f = ~st_reg.filt[PIN_ENB_BIT];
  assign adr_f = st_reg.filt[ADDR_W-1:0];
  assign pkt_level = ~cell_mode & ~byte_level;
  // Byte-level reads the port named this cycle, other styles the latch
  assign target = (byte_level && !cell_mode) ? adr_f : st_reg.sel;

  // Fetch path into the buffer; an empty FIFO still yields an entry
  // marked as no-data, so the output stage always gets an answer
  assign take_data = port_data[st_reg.fetch_port*DATA_W +: DATA_W];
  assign buf_in_valid = (st_reg.fetch == FETCH_TAKE);
  assign buf_in_data = {port_valid[st_reg.fetch_port],
                        port_sop[st_reg.fetch_port] &
                        port_valid[st_reg.fetch_port],
                        take_data};
  // Output stage drains only when a read edge is still unanswered
  assign buf_out_ready = st_reg.drive_pend;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rdy = '0;

    // Three-stage sampler; a bit rises once stages two and three agree high and clears as soon as they differ
    st_next.s1 = {rfclk, renb_n, radr};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.filt = (st_reg.s2 & st_reg.s3) |
                   (st_reg.filt & ~(st_reg.s2 ^ st_reg.s3));
    st_next.clk_prev = st_reg.filt[PIN_CLK_BIT];

    // Direct availability outputs follow the FIFO flags every cycle
    st_next.dpa = pkt_avail;

    // Link edge handling
    if (link_rise) begin
      if (enb_f) begin
        // Read cycle
        if (byte_level && !cell_mode) begin
          st_next.sel = adr_f;
        end
        if (owned(target)) begin
          st_next.fetch = FETCH_ASK;
          st_next.fetch_port = target[PORT_W-1:0];
          st_next.drive_pend = 1'b1;
        end else begin
          // Null or foreign address: float data, parity and start flag, nothing valid
          st_next.dat_oe = 1'b0;
          st_next.prty_oe = 1'b0;
          st_next.sop_oe = 1'b0;
          st_next.val = 1'b0;
        end
      end else begin
        // Enable high: no read, data, parity and start flag float, valid drops
        st_next.dat_oe = 1'b0;
        st_next.prty_oe = 1'b0;
        st_next.sop_oe = 1'b0;
        st_next.val = 1'b0;
        st_next.drive_pend = 1'b0;
        if (!(byte_level && !cell_mode)) begin
          // Cell mode and packet-level select here; byte-level does not
          st_next.sel = adr_f;
        end
      end

      // Polling answers in packet-level in both phases; the selection
      // only moves in the selection phase handled above
      if (pkt_level) begin
        st_next.rpa_oe = owned(adr_f);
        st_next.rpa = owned(adr_f) & pkt_avail[adr_f[PORT_W-1:0]];
      end else begin
        st_next.rpa_oe = 1'b0;
        st_next.rpa = 1'b0;
      end
    end

    // Fetch sequencer: ask only when the buffer has room, so the word
    // popped from the FIFO always has a place to land
    unique case (st_reg.fetch)
      FETCH_IDLE: begin
      end
      FETCH_ASK: begin
        if (buf_in_ready) begin
          st_next.rdy[st_reg.fetch_port] = 1'b1;
          st_next.fetch = FETCH_TAKE;
        end
      end
      FETCH_TAKE: begin
        st_next.fetch = FETCH_IDLE;
      end
      default: begin
        st_next.fetch = FETCH_IDLE;
      end
    endcase

    // Output stage loads the answer for the last read edge. Enable may
    // rise again right after that edge; the word is already out of its
    // FIFO, so it is still shown and only the next edge floats the pins.
    if (st_reg.drive_pend && buf_out_valid) begin
      st_next.drive_pend = 1'b0;
      st_next.dat = buf_out_data[DATA_W-1:0];
      st_next.prty = (^buf_out_data[DATA_W-1:0]) ^ parity_odd;
      st_next.sop = buf_out_data[BUF_SOP_BIT] &
                    buf_out_data[BUF_HAS_BIT];
      st_next.val = buf_out_data[BUF_HAS_BIT];
      st_next.dat_oe = 1'b1;
      st_next.prty_oe = 1'b1;
      st_next.sop_oe = 1'b1;
    end

    if (srst) begin
      st_next = '0;
      st_next.sel = SEL_RESET;
      st_next.fetch = FETCH_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Data path buffer
  // ---------------------------------------------------------------
  // Two entries absorb a late drain: a fetched word waits here if the
  // output stage is not yet due, instead of being dropped.
  word_buffer u_buf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // ---------------------------------------------------------------
  // Outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign rdat_o = st_reg.dat;
  assign rdat_oe = st_reg.dat_oe;
  assign rprty_o = st_reg.prty;
  assign rprty_oe = st_reg.prty_oe;
  assign rsop_o = st_reg.sop;
  assign rsop_oe = st_reg.sop_oe;
  assign rval = st_reg.val;
  assign rpa_o = st_reg.rpa;
  assign rpa_oe = st_reg.rpa_oe;
  assign direct_packet_avail = st_reg.dpa;
  assign port_ready = st_reg.rdy;

endmodule

// ===== rx_read_port_asserts.sv
// Concurrent checks on the pins of the receive multi-PHY read port
`timescale 1ns/1ps
module rx_read_port_asserts (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cell_mode,
  input wire logic byte_level,
  input wire logic rdat_oe,
  input wire logic rprty_oe,
  input wire logic rsop_o,
  input wire logic rsop_oe,
  input wire logic rval,
  input wire logic rpa_oe,
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] direct_packet_avail,
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] port_valid,
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] pkt_avail,
  input wire logic [rx_read_pkg::NUM_PORTS-1:0] port_ready
);
  import rx_read_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // A pop from a FIFO head, and the word it becomes on the data pins
  sequence s_pop;
    |(port_ready & port_valid);
  endsequence
  sequence s_word;
    rval && rdat_oe;
  endsequence

  a_oe_group:
    assert property (rsop_oe == rdat_oe && rprty_oe == rdat_oe)
    else $error("output enables disagree");
  a_val_driven:
    assert property (rval |-> rdat_oe) else $error("valid while floating");
  a_sop_valid:
    assert property (rsop_oe && rsop_o |-> rval)
    else $error("start flag on an invalid word");
  a_ready_single:
    assert property ($onehot0(port_ready)) else $error("two ports popped");
  a_ready_pulse:
    assert property (port_ready != 4'h0 |=> port_ready == 4'h0)
    else $error("pop held for two cycles");
  // Word is shown two cycles after the pop and held until the next link edge, so ##[3:5] sees it
  a_pop_word:
    assert property (s_pop |-> ##[3:5] s_word)
    else $error("popped word never shown");
  a_direct_avail:
    assert property (!$past(srst) |->
      direct_packet_avail == $past(pkt_avail))
    else $error("direct availability wrong");
  a_no_poll:
    assert property (cell_mode || byte_level |-> !rpa_oe)
    else $error("poll output driven outside packet level");
endmodule

// ===== rx_link_ctrl.sv
// Link-layer controller model driving the receive read pins
`timescale 1ns/1ps
module rx_link_ctrl (
  output logic rfclk,
  output logic renb_n,
  output logic [rx_read_pkg::ADDR_W-1:0] radr
);
  import rx_read_pkg::*;
  // Interface clock stands low between transfers; enable idles high
  initial begin
    rfclk = 1'b0;
    renb_n = 1'b1;
    radr = NULL_ADDR;
  end
  // One 800 ns clock cycle plus 400 ns idle; pins move half a period ahead of the rising edge so the
  // eight-times-faster core-clock sampler never catches them changing
  task automatic xfer(input logic en_n, input logic [ADDR_W-1:0] a);
    renb_n = en_n;
    radr = a;
    #400 rfclk = 1'b1;
    #400 rfclk = 1'b0;
    // Enable goes back to idle while the answer is still in flight
    renb_n = 1'b1;
    #400;
  endtask
endmodule

// ===== rx_multiphy_read_port_tb_top.sv
// Testbench top for the receive multi-PHY read port
`timescale 1ns/1ps
module rx_multiphy_read_port_tb_top;
  import rx_read_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cell_mode = 1'b0;
  logic byte_level = 1'b0;
  logic parity_odd = 1'b0;
  logic rfclk, renb_n, rdat_oe, rprty_o, rprty_oe, rsop_o, rsop_oe;
  logic rval, rpa_o, rpa_oe, clr;
  logic [ADDR_W-1:0] radr;
  logic [DATA_W-1:0] rdat_o;
  logic [NUM_PORTS-1:0] direct_packet_avail, port_sop, port_ready, pop;
  logic [NUM_PORTS-1:0] port_valid = 4'hf;
  logic [NUM_PORTS-1:0] pkt_avail = 4'h5;
  logic [NUM_PORTS*DATA_W-1:0] port_data;
  logic [11:0] cnt [NUM_PORTS];
  logic [11:0] exp_cnt [NUM_PORTS];
  int failures = 0;
  int n_checks = 0;

  rx_multiphy_read_port u_dut (.*);
  rx_link_ctrl u_link (.rfclk, .renb_n, .radr);

  always #50 ref_clk = ~ref_clk;

  // FIFO heads: word n of port p is {p, n}; word 0 opens the packet
  always @(posedge ref_clk) begin
    pop = port_ready & port_valid;
    clr = srst;
    #1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (clr) cnt[p] = 12'h000;
      else if (pop[p]) cnt[p] = cnt[p] + 12'h001;
    end
  end
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_sop[p] = (cnt[p] == 12'h000);
      port_data[p*DATA_W +: DATA_W] = {4'(p), cnt[p]};
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Mode straps change only under reset, so no stale poll output remains
  task automatic reset_to(input logic c, input logic b);
    srst = 1'b1;
    cell_mode = c;
    byte_level = b;
    parity_odd = b;
    repeat (20) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) exp_cnt[p] = 12'h000;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  // One link edge, then judge the pins once the answer has landed
  task automatic step(input logic en_n, input logic [4:0] a,
                      input logic rd, input logic [1:0] p);
    logic [15:0] w;
    w = {2'h0, p, exp_cnt[p]};
    u_link.xfer(en_n, a);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("rdat_oe", 16'(rd), 16'(rdat_oe));
    chk("rsop_oe", 16'(rd), 16'(rsop_oe));
    chk("rprty_oe", 16'(rd), 16'(rprty_oe));
    chk("rval", 16'(rd), 16'(rval));
    if (rd) begin
      chk("rdat_o", w, rdat_o);
      chk("rsop_o", 16'(w[11:0] == 12'h000), 16'(rsop_o));
      chk("rprty_o", 16'(^w ^ parity_odd), 16'(rprty_o));
      exp_cnt[p] = w[11:0] + 12'h001;
    end
    if (!cell_mode && !byte_level) begin
      chk("rpa_oe", 16'(a < 5'h04), 16'(rpa_oe));
      if (a < 5'h04) chk("rpa_o", 16'(pkt_avail[a[1:0]]), 16'(rpa_o));
    end else chk("rpa_oe", 16'h0, 16'(rpa_oe));
  endtask

  task automatic t_cell();
    reset_to(1'b1, 1'b0);
    step(1'b1, 5'h03, 1'b0, 2'h0);
    step(1'b0, 5'h05, 1'b1, 2'h3);
    step(1'b0, 5'h00, 1'b1, 2'h3);
    step(1'b1, 5'h1f, 1'b0, 2'h0);
    step(1'b0, 5'h03, 1'b0, 2'h0);
    step(1'b1, 5'h03, 1'b0, 2'h0);
    step(1'b0, 5'h03, 1'b1, 2'h3);
    $display("cell mode test done");
  endtask

  task automatic t_byte();
    reset_to(1'b0, 1'b1);
    pkt_avail = 4'h9;
    step(1'b0, 5'h00, 1'b1, 2'h0);
    step(1'b0, 5'h02, 1'b1, 2'h2);
    step(1'b1, 5'h01, 1'b0, 2'h0);
    step(1'b0, 5'h01, 1'b1, 2'h1);
    step(1'b0, 5'h1f, 1'b0, 2'h0);
    step(1'b0, 5'h07, 1'b0, 2'h0);
    chk("direct_packet_avail", 16'(pkt_avail), 16'(direct_packet_avail));
    $display("byte level test done");
  endtask

  task automatic t_pkt();
    reset_to(1'b0, 1'b0);
    step(1'b1, 5'h02, 1'b0, 2'h0);
    step(1'b0, 5'h00, 1'b1, 2'h2);
    step(1'b0, 5'h01, 1'b1, 2'h2);
    step(1'b1, 5'h02, 1'b0, 2'h0);
    step(1'b0, 5'h03, 1'b1, 2'h2);
    step(1'b1, 5'h06, 1'b0, 2'h0);
    step(1'b0, 5'h02, 1'b0, 2'h0);
    pkt_avail = 4'ha;
    step(1'b1, 5'h02, 1'b0, 2'h0);
    // Empty head: pins driven, nothing marked valid, nothing popped
    port_valid = 4'hb;
    u_link.xfer(1'b0, 5'h01);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("empty rdat_oe", 16'h1, 16'(rdat_oe));
    chk("empty rval", 16'h0, 16'(rval));
    chk("empty rsop_o", 16'h0, 16'(rsop_o));
    port_valid = 4'hf;
    step(1'b0, 5'h03, 1'b1, 2'h2);
    $display("packet level test done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    t_cell();
    t_byte();
    t_pkt();
    report_and_stop();
  end

  // Watchdog: the three tests need about 450 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule

bind rx_multiphy_read_port rx_read_port_asserts u_chk (
  .ref_clk, .srst, .cell_mode, .byte_level, .rdat_oe, .rprty_oe, .rsop_o,
  .rsop_oe, .rval, .rpa_oe, .direct_packet_avail, .port_valid, .pkt_avail,
  .port_ready);
